// ---- design/serial_bus_port.sv ----
// Two-wire serial slave front end: pin synchronisers, byte framing, acknowledge and timeout.
`timescale 1ns/1ps
module serial_bus_port
#(
   parameter logic [6:0] DEVICE_ADDRESS = 7'h20,
   parameter int TIMEOUT_LIMIT = regcfg_pkg::TIMEOUT_CYCLES
)
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Bus pins.
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_drive_n,
   // Byte side.
   input wire logic timeout_enable,
   input wire logic [7:0] tx_byte,
   output logic rx_valid,
   output logic rx_first,
   output logic [7:0] rx_byte,
   output logic timeout_pulse
);
   import regcfg_pkg::*;

   initial
   begin
      if (TIMEOUT_LIMIT < 1 || TIMEOUT_LIMIT >= (1 << TIMEOUT_WIDTH))
      begin
         $error("Timeout limit out of range.");
      end
   end

   typedef struct packed
   {
      logic [2:0] scl_sync;
      logic [2:0] sda_sync;
      logic scl_f;
      logic sda_f;
      bus_state_e state;
      logic [3:0] bits;
      logic [7:0] shreg;
      logic rw;
      logic first;
      logic drive;
      logic rx_valid;
      logic [7:0] rx_byte;
      logic [TIMEOUT_WIDTH-1:0] idle_cnt;
      logic timeout_pulse;
   } port_s;

   port_s st_reg;
   port_s st_next;
   logic scl_n;
   logic sda_n;
   logic scl_rise;
   logic scl_fall;

   // =========================================================
   // Next state
   always_comb
   begin
      st_next = st_reg;
      st_next.scl_sync = {st_reg.scl_sync[1:0], scl_in};
      st_next.sda_sync = {st_reg.sda_sync[1:0], sda_in};
      scl_n = (st_reg.scl_sync[1] == st_reg.scl_sync[2]) ? st_reg.scl_sync[2] : st_reg.scl_f;
      sda_n = (st_reg.sda_sync[1] == st_reg.sda_sync[2]) ? st_reg.sda_sync[2] : st_reg.sda_f;
      st_next.scl_f = scl_n;
      st_next.sda_f = sda_n;
      scl_rise = scl_n && !st_reg.scl_f;
      scl_fall = !scl_n && st_reg.scl_f;
      st_next.rx_valid = 1'b0;
      st_next.timeout_pulse = 1'b0;
      case (st_reg.state)
         ST_ADDR, ST_WRITE:
         begin
            if (scl_rise)
            begin
               st_next.shreg = {st_reg.shreg[6:0], sda_n};
               st_next.bits = st_reg.bits + 4'd1;
            end
            else if (scl_fall && st_reg.bits == 4'd8)
            begin
               st_next.bits = 4'd0;
               if (st_reg.state == ST_WRITE)
               begin
                  st_next.rx_valid = 1'b1;
                  st_next.rx_byte = st_reg.shreg;
                  st_next.drive = 1'b1;
                  st_next.state = ST_WRITE_ACK;
               end
               else if (st_reg.shreg[7:1] == DEVICE_ADDRESS)
               begin
                  st_next.rw = st_reg.shreg[0];
                  st_next.first = 1'b1;
                  st_next.drive = 1'b1;
                  st_next.state = ST_ADDR_ACK;
               end
               else
               begin
                  st_next.state = ST_IDLE;
               end
            end
         end
         ST_ADDR_ACK, ST_WRITE_ACK:
         begin
            if (scl_fall)
            begin
               if (st_reg.state == ST_WRITE_ACK)
               begin
                  st_next.first = 1'b0;
               end
               if (st_reg.rw)
               begin
                  st_next.shreg = tx_byte;
                  st_next.drive = !tx_byte[7];
                  st_next.state = ST_READ;
               end
               else
               begin
                  st_next.drive = 1'b0;
                  st_next.state = ST_WRITE;
               end
            end
         end
         ST_READ:
         begin
            if (scl_fall)
            begin
               if (st_reg.bits == 4'd7)
               begin
                  st_next.bits = 4'd0;
                  st_next.drive = 1'b0;
                  st_next.state = ST_READ_ACK;
               end
               else
               begin
                  st_next.bits = st_reg.bits + 4'd1;
                  st_next.shreg = {st_reg.shreg[6:0], 1'b0};
                  st_next.drive = !st_reg.shreg[6];
               end
            end
         end
         ST_READ_ACK:
         begin
            if (scl_rise && sda_n)
            begin
               st_next.state = ST_IDLE;
            end
            else if (scl_fall)
            begin
               st_next.shreg = tx_byte;
               st_next.drive = !tx_byte[7];
               st_next.state = ST_READ;
            end
         end
         default:
         begin
            st_next.drive = 1'b0;
         end
      endcase
      if (st_reg.state == ST_IDLE || scl_rise || scl_fall || !timeout_enable)
      begin
         st_next.idle_cnt = '0;
      end
      else if (st_reg.idle_cnt == TIMEOUT_WIDTH'(TIMEOUT_LIMIT))
      begin
         st_next.state = ST_IDLE;
         st_next.drive = 1'b0;
         st_next.timeout_pulse = 1'b1;
         st_next.idle_cnt = '0;
      end
      else
      begin
         st_next.idle_cnt = st_reg.idle_cnt + TIMEOUT_WIDTH'(1);
      end
      if (scl_n && st_reg.scl_f && st_reg.sda_f && !sda_n)
      begin
         st_next.state = ST_ADDR;
         st_next.bits = 4'd0;
         st_next.drive = 1'b0;
      end
      else if (scl_n && st_reg.scl_f && !st_reg.sda_f && sda_n)
      begin
         st_next.state = ST_IDLE;
         st_next.drive = 1'b0;
      end
   end

   // =========================================================
   // State register
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         st_reg <= '{scl_sync: 3'b111, sda_sync: 3'b111, scl_f: 1'b1, sda_f: 1'b1,
                     state: ST_IDLE, rx_byte: 8'h00_00, shreg: 8'h00_00, default: '0};
      end
      else if (ce)
      begin
         st_reg <= st_next;
      end
   end

   assign sda_drive_n = !st_reg.drive;
   assign rx_valid = st_reg.rx_valid;
   assign rx_first = st_reg.first;
   assign rx_byte = st_reg.rx_byte;
   assign timeout_pulse = st_reg.timeout_pulse;

endmodule

// ---- design/regcfg_pkg.sv ----
// Package with offsets, field positions, reset values and timing of the configuration registers.
package regcfg_pkg;

   // =========================================================
   // Register offsets
   localparam logic [7:0] OFS_LOCK_AND_SOFT_RESET = 8'h00_D0;
   localparam logic [7:0] OFS_MANUFACTURER_CONFIGURATION = 8'h00_D1;
   localparam logic [7:0] OFS_REGULATOR_CONFIG_PRIMARY = 8'h00_D2;
   localparam logic [7:0] OFS_REGULATOR_CONFIG_COMPANION = 8'h00_D3;

   // =========================================================
   // Reset values
   localparam logic [7:0] RST_LOCK_AND_SOFT_RESET = 8'h00_00;
   localparam logic [7:0] RST_MANUFACTURER_CONFIGURATION = 8'h00_07;
   localparam logic [7:0] RST_REGULATOR_CONFIG = 8'h00_52;
   localparam logic [7:0] RST_ZERO = 8'h00_00;

   // =========================================================
   // Field positions
   localparam int LOCK_BIT = 0;
   localparam int SOFT_RESET_BIT = 1;
   localparam int LP_PHASE_MSB = 7;
   localparam int LP_PHASE_LSB = 6;
   localparam int BUS_TIMEOUT_BIT = 3;
   localparam int FAULT_EN_BIT = 2;
   localparam int ALERT_EN_BIT = 1;
   localparam int MONITOR_EN_BIT = 0;
   localparam int PHASE_MSB = 6;
   localparam int PHASE_LSB = 4;
   localparam int VOLTAGE_SELECT_BIT = 3;
   localparam int LOOP_EN_BIT = 2;
   localparam logic [7:0] MFR_WRITE_MASK = 8'h00_CF;

   // =========================================================
   // Bus timeout
   localparam int TIMEOUT_MS = 35;
   localparam int CLK_HZ = 25_000_000;
   localparam int TIMEOUT_CYCLES = (CLK_HZ / 1000) * TIMEOUT_MS;
   localparam int TIMEOUT_WIDTH = 20;

   // =========================================================
   // Bus front end states
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_ADDR_ACK = 3'b010,
      ST_WRITE = 3'b011,
      ST_WRITE_ACK = 3'b100,
      ST_READ = 3'b101,
      ST_READ_ACK = 3'b110
   } bus_state_e;

endpackage

// ---- design/regulator_mfr_config_registers.sv ----
// Manufacturer configuration registers of a multiphase regulator controller.
`timescale 1ns/1ps
// Summary of operation
// - Writing one to the soft reset bit restores all registers unless locked.
// - Setting the lock bit makes lockable registers read-only until power cycles.
// - Low-power phase count: 00 one, 01 two, 10 three, 11 one.
// - With timeout enabled, a bus stall over 35 ms releases the bus.
// - Fault pin enable bit gates the fault pin and resets to one.
// - Alert pin is driven only while its enable bit is one.
// - Monitor enable bit starts conversions of voltages and temperatures.
// - Phase code 000 to 101 gives one to six phases, others six.
// - Voltage select picks setpoint register code or voltage code pins.
// - Loop test enabled only when bit 2 is set in both configs.
// - Companion config has same layout; functions need bits set in both.
module regulator_mfr_config_registers
#(
   parameter logic [6:0] DEVICE_ADDRESS = 7'h20,
   parameter int TIMEOUT_LIMIT = regcfg_pkg::TIMEOUT_CYCLES
)
(
   // Clock, reset and clock enable.
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Serial bus pins.
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   // Voltage code sources.
   input wire logic [7:0] voltage_code_inputs,
   input wire logic [7:0] output_voltage_setpoint_reg,
   output logic [7:0] voltage_code_out,
   // Fault and alert pins.
   input wire logic fault_request,
   input wire logic alert_request,
   output logic fault_pin_n,
   output logic alert_pin_oe_n,
   // Regulator controls.
   output logic [2:0] low_power_state_phase_count,
   output logic [2:0] active_phase_count,
   output logic register_voltage_select,
   output logic conversion_enable,
   output logic loop_test_enable,
   output logic bus_timeout_enable,
   output logic locked,
   output logic bus_timeout_event
);
   import regcfg_pkg::*;

   // =========================================================
   // Decoders
   function automatic logic [2:0] lowpower_count(input logic [1:0] code);
      lowpower_count = (code == 2'b01) ? 3'd2 : (code == 2'b10) ? 3'd3 : 3'd1;
   endfunction

   function automatic logic [2:0] phase_count(input logic [2:0] code);
      phase_count = (code <= 3'b101) ? code + 3'd1 : 3'd6;
   endfunction

   typedef struct packed
   {
      logic lock;
      logic [7:0] mfr;
      logic [7:0] cfg_a;
      logic [7:0] cfg_b;
      logic [7:0] pointer;
      logic [7:0] rd_byte;
      logic [2:0][7:0] vc_sync;
      logic [7:0] vc_f;
      logic [7:0] voltage_code;
      logic [2:0] lp_phases;
      logic [2:0] phases;
      logic vsel;
      logic monitor;
      logic loop;
      logic fault_n;
      logic alert_oe_n;
      logic timeout_event;
   } bank_s;

   bank_s st_reg;
   bank_s st_next;
   logic rx_valid;
   logic rx_first;
   logic [7:0] rx_byte;
   logic timeout_pulse;
   logic sda_drive_n;
   logic [7:0] both;

   // =========================================================
   // Bus front end
   serial_bus_port
   #(
      .DEVICE_ADDRESS(DEVICE_ADDRESS),
      .TIMEOUT_LIMIT(TIMEOUT_LIMIT)
   )
   u_port
   (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .sda_drive_n(sda_drive_n),
      .timeout_enable(st_reg.mfr[BUS_TIMEOUT_BIT]),
      .tx_byte(st_reg.rd_byte),
      .rx_valid(rx_valid),
      .rx_first(rx_first),
      .rx_byte(rx_byte),
      .timeout_pulse(timeout_pulse)
   );

   // =========================================================
   // Next state
   always_comb
   begin
      st_next = st_reg;
      if (rx_valid && rx_first)
      begin
         st_next.pointer = rx_byte;
      end
      else if (rx_valid && !st_reg.lock)
      begin
         case (st_reg.pointer)
            OFS_LOCK_AND_SOFT_RESET:
            begin
               if (rx_byte[SOFT_RESET_BIT])
               begin
                  st_next.mfr = RST_MANUFACTURER_CONFIGURATION;
                  st_next.cfg_a = RST_REGULATOR_CONFIG;
                  st_next.cfg_b = RST_REGULATOR_CONFIG;
               end
               else
               begin
                  st_next.lock = rx_byte[LOCK_BIT];
               end
            end
            OFS_MANUFACTURER_CONFIGURATION:
            begin
               st_next.mfr = rx_byte & MFR_WRITE_MASK;
            end
            OFS_REGULATOR_CONFIG_PRIMARY:
            begin
               st_next.cfg_a = rx_byte;
            end
            OFS_REGULATOR_CONFIG_COMPANION:
            begin
               st_next.cfg_b = rx_byte;
            end
            default:
            begin
               st_next.pointer = st_reg.pointer;
            end
         endcase
      end
      case (st_next.pointer)
         OFS_LOCK_AND_SOFT_RESET: st_next.rd_byte = {7'd0, st_next.lock};
         OFS_MANUFACTURER_CONFIGURATION: st_next.rd_byte = st_next.mfr;
         OFS_REGULATOR_CONFIG_PRIMARY: st_next.rd_byte = st_next.cfg_a;
         OFS_REGULATOR_CONFIG_COMPANION: st_next.rd_byte = st_next.cfg_b;
         default: st_next.rd_byte = RST_ZERO;
      endcase
      st_next.vc_sync = {st_reg.vc_sync[1:0], voltage_code_inputs};
      for (int i = 0; i < 8; i++)
      begin
         if (st_reg.vc_sync[1][i] == st_reg.vc_sync[2][i])
         begin
            st_next.vc_f[i] = st_reg.vc_sync[2][i];
         end
      end
      both = st_reg.cfg_a & st_reg.cfg_b;
      st_next.lp_phases = lowpower_count(st_reg.mfr[LP_PHASE_MSB:LP_PHASE_LSB]);
      st_next.phases = phase_count(both[PHASE_MSB:PHASE_LSB]);
      st_next.vsel = both[VOLTAGE_SELECT_BIT];
      st_next.voltage_code = both[VOLTAGE_SELECT_BIT] ? output_voltage_setpoint_reg
                                                      : st_reg.vc_f;
      st_next.loop = both[LOOP_EN_BIT];
      st_next.monitor = st_reg.mfr[MONITOR_EN_BIT];
      st_next.fault_n = !(fault_request && st_reg.mfr[FAULT_EN_BIT]);
      st_next.alert_oe_n = !(alert_request && st_reg.mfr[ALERT_EN_BIT]);
      st_next.timeout_event = timeout_pulse;
   end

   // =========================================================
   // State register
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         st_reg <= '{lock: RST_LOCK_AND_SOFT_RESET[LOCK_BIT],
                     mfr: RST_MANUFACTURER_CONFIGURATION,
                     cfg_a: RST_REGULATOR_CONFIG,
                     cfg_b: RST_REGULATOR_CONFIG,
                     lp_phases: 3'd1, phases: 3'd1,
                     fault_n: 1'b1, alert_oe_n: 1'b1, default: '0};
      end
      else if (ce)
      begin
         st_reg <= st_next;
      end
   end

   // =========================================================
   // Outputs
   assign sda_out = 1'b0;
   assign sda_oe_n = sda_drive_n;
   assign voltage_code_out = st_reg.voltage_code;
   assign fault_pin_n = st_reg.fault_n;
   assign alert_pin_oe_n = st_reg.alert_oe_n;
   assign low_power_state_phase_count = st_reg.lp_phases;
   assign active_phase_count = st_reg.phases;
   assign register_voltage_select = st_reg.vsel;
   assign conversion_enable = st_reg.monitor;
   assign loop_test_enable = st_reg.loop;
   assign bus_timeout_enable = st_reg.mfr[BUS_TIMEOUT_BIT];
   assign locked = st_reg.lock;
   assign bus_timeout_event = st_reg.timeout_event;

endmodule

// ---- tb/i2c_host_model.sv ----
// Behavioural two-wire bus host that drives the clock and data lines.
`timescale 1ns/1ps
module i2c_host_model
(
   // Clock.
   input wire logic clk,
   // Bus lines.
   output logic scl,
   output logic sda_drv,
   input wire logic sda_bus
);
   initial
   begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   task automatic half();
      repeat (10) @(posedge clk);
   endtask
   task automatic start();
      sda_drv <= 1'b1;
      half();
      scl <= 1'b1;
      half();
      sda_drv <= 1'b0;
      half();
      scl <= 1'b0;
      half();
   endtask
   task automatic stop();
      sda_drv <= 1'b0;
      half();
      scl <= 1'b1;
      half();
      sda_drv <= 1'b1;
      half();
   endtask
   task automatic bit_io(input logic b, output logic r);
      sda_drv <= b;
      half();
      scl <= 1'b1;
      half();
      r = sda_bus;
      scl <= 1'b0;
      half();
   endtask
   task automatic byte_wr(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_io(b[i], r);
      bit_io(1'b1, r);
      ack = ~r;
   endtask
   task automatic byte_rd(output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         bit_io(1'b1, r);
         d[i] = r;
      end
      bit_io(1'b1, r);
   endtask
endmodule

// ---- tb/regcfg_chk.sv ----
// Concurrent checks on the ports of the configuration register block.
`timescale 1ns/1ps
module regcfg_chk
#(
   parameter int TIMEOUT_LIMIT = 200
)
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Observed ports.
   input wire logic scl_in,
   input wire logic fault_request,
   input wire logic alert_request,
   input wire logic [7:0] output_voltage_setpoint_reg,
   input wire logic sda_oe_n,
   input wire logic fault_pin_n,
   input wire logic alert_pin_oe_n,
   input wire logic [7:0] voltage_code_out,
   input wire logic [2:0] low_power_state_phase_count,
   input wire logic [2:0] active_phase_count,
   input wire logic register_voltage_select,
   input wire logic loop_test_enable,
   input wire logic bus_timeout_enable,
   input wire logic locked,
   input wire logic bus_timeout_event
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // =========================================================
   // Cycles since the bus clock pin last changed.
   int idle_cnt;
   logic scl_q;
   always_ff @(posedge clk)
   begin
      scl_q <= scl_in;
      idle_cnt <= (rst || scl_in != scl_q) ? 0 : idle_cnt + 1;
   end
   // =========================================================
   // Properties.
   property p_fault;
      !fault_pin_n |-> $past(fault_request);
   endproperty
   a_fault: assert property (p_fault) else $error("fault pin without request");
   property p_alert;
      !alert_pin_oe_n |-> $past(alert_request);
   endproperty
   a_alert: assert property (p_alert) else $error("alert pin without request");
   property p_lock_hold;
      locked |=> locked;
   endproperty
   a_lock_hold: assert property (p_lock_hold) else $error("lock dropped");
   property p_lock_freeze;
      locked && $past(locked) |-> $stable(low_power_state_phase_count)
         && $stable(active_phase_count) && $stable(bus_timeout_enable);
   endproperty
   a_lock_freeze: assert property (p_lock_freeze) else $error("locked field moved");
   property p_lp_count;
      low_power_state_phase_count inside {3'h1, 3'h2, 3'h3};
   endproperty
   a_lp_count: assert property (p_lp_count) else $error("low power count out of range");
   property p_phase;
      active_phase_count inside {[3'h1:3'h6]};
   endproperty
   a_phase: assert property (p_phase) else $error("phase count out of range");
   property p_vsel;
      register_voltage_select && $past(register_voltage_select, 2)
         |-> voltage_code_out == $past(output_voltage_setpoint_reg);
   endproperty
   a_vsel: assert property (p_vsel) else $error("setpoint code not selected");
   property p_tmo_gate;
      bus_timeout_event |-> bus_timeout_enable;
   endproperty
   a_tmo_gate: assert property (p_tmo_gate) else $error("timeout while disabled");
   property p_tmo_len;
      bus_timeout_event |-> idle_cnt inside {[TIMEOUT_LIMIT:TIMEOUT_LIMIT + 8]};
   endproperty
   a_tmo_len: assert property (p_tmo_len) else $error("timeout at wrong time");
   property p_tmo_rel;
      bus_timeout_event |=> sda_oe_n [*4];
   endproperty
   a_tmo_rel: assert property (p_tmo_rel) else $error("data line held after timeout");
   c_tmo: cover property (bus_timeout_event);
   c_loop: cover property ($rose(loop_test_enable));
   c_lock: cover property ($rose(locked));
   c_fault: cover property (!fault_pin_n);
endmodule
bind regulator_mfr_config_registers regcfg_chk #(.TIMEOUT_LIMIT(TIMEOUT_LIMIT)) u_chk
(
   .clk, .rst, .scl_in, .fault_request, .alert_request, .output_voltage_setpoint_reg,
   .sda_oe_n, .fault_pin_n, .alert_pin_oe_n, .voltage_code_out, .low_power_state_phase_count,
   .active_phase_count, .register_voltage_select, .loop_test_enable, .bus_timeout_enable,
   .locked, .bus_timeout_event
);

// ---- tb/tb_top.sv ----
// Self-checking bench for the configuration registers behind the two-wire bus.
`timescale 1ns/1ps
module tb_top;
   import regcfg_pkg::*;
   localparam logic [6:0] ADDR = 7'h20;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic fault_request = 1'b0;
   logic alert_request = 1'b0;
   logic [7:0] pins = 8'h00_3C;
   logic [7:0] setpoint = 8'h00_A5;
   logic scl, sda_drv, sda_out, sda_oe_n, fault_pin_n, alert_pin_oe_n, vsel, conv;
   logic loop_en, tmo_en, locked, tmo_ev;
   logic [7:0] vout;
   logic [2:0] lp_cnt, ph_cnt;
   int error_cnt = 0;
   int checks_done = 0;
   int cyc = 0;
   wire sda_bus = sda_drv & (sda_oe_n | sda_out);
   always #20 clk = ~clk;
   i2c_host_model u_host (.clk(clk), .scl(scl), .sda_drv(sda_drv), .sda_bus(sda_bus));
   regulator_mfr_config_registers #(.DEVICE_ADDRESS(ADDR), .TIMEOUT_LIMIT(200))
      u_regulator_mfr_config_registers (.clk(clk), .rst(rst), .ce(1'b1), .scl_in(scl),
      .sda_in(sda_bus), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .voltage_code_inputs(pins),
      .output_voltage_setpoint_reg(setpoint), .voltage_code_out(vout),
      .fault_request(fault_request), .alert_request(alert_request), .fault_pin_n(fault_pin_n),
      .alert_pin_oe_n(alert_pin_oe_n), .low_power_state_phase_count(lp_cnt),
      .active_phase_count(ph_cnt), .register_voltage_select(vsel), .conversion_enable(conv),
      .loop_test_enable(loop_en), .bus_timeout_enable(tmo_en), .locked(locked),
      .bus_timeout_event(tmo_ev));
   // =========================================================
   // Access and comparison tasks.
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic chk1(input string what, input logic seen, input logic exp);
      check(what, {7'h00, seen}, {7'h00, exp});
   endtask
   task automatic wr(input logic [7:0] cmd, input logic [7:0] d);
      logic a;
      u_host.start();
      u_host.byte_wr({ADDR, 1'b0}, a);
      u_host.byte_wr(cmd, a);
      u_host.byte_wr(d, a);
      u_host.stop();
      chk1("write ack", a, 1'b1);
   endtask
   task automatic rd(input logic [7:0] cmd, input logic [7:0] exp);
      logic a;
      logic [7:0] d;
      u_host.start();
      u_host.byte_wr({ADDR, 1'b0}, a);
      u_host.byte_wr(cmd, a);
      u_host.start();
      u_host.byte_wr({ADDR, 1'b1}, a);
      u_host.byte_rd(d);
      u_host.stop();
      check("read data", d, exp);
   endtask
   task automatic stall(input logic [7:0] exp);
      logic a;
      int n;
      logic [7:0] d;
      n = 0;
      u_host.start();
      u_host.byte_wr({ADDR, 1'b1}, a);
      repeat (400)
      begin
         @(negedge clk);
         if (tmo_ev === 1'b1)
            n++;
      end
      check("timeout pulses", n[7:0], exp);
      chk1("data released", sda_oe_n, exp[0]);
      @(posedge clk);
      u_host.byte_rd(d);
      u_host.stop();
   endtask
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         error_cnt++;
         give_verdict();
      end
   end
   // =========================================================
   // Test sequence.
   initial
   begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      repeat (5) @(posedge clk);
      rd(OFS_LOCK_AND_SOFT_RESET, 8'h00_00);
      rd(OFS_MANUFACTURER_CONFIGURATION, 8'h00_07);
      rd(OFS_REGULATOR_CONFIG_PRIMARY, 8'h00_52);
      check("phases", {5'h00, ph_cnt}, 8'h06);
      chk1("conversion", conv, 1'b1);
      fault_request <= 1'b1;
      alert_request <= 1'b1;
      repeat (5) @(posedge clk);
      chk1("fault pin", fault_pin_n, 1'b0);
      chk1("alert pin", alert_pin_oe_n, 1'b0);
      wr(OFS_MANUFACTURER_CONFIGURATION, 8'h00_F8);
      rd(OFS_MANUFACTURER_CONFIGURATION, 8'h00_C8);
      chk1("fault pin", fault_pin_n, 1'b1);
      chk1("alert pin", alert_pin_oe_n, 1'b1);
      chk1("conversion", conv, 1'b0);
      chk1("timeout enable", tmo_en, 1'b1);
      $display("test reset and enables done");
      for (int i = 0; i < 4; i++)
      begin
         wr(OFS_MANUFACTURER_CONFIGURATION, {i[1:0], 6'h07});
         check("low power count", {5'h00, lp_cnt}, (i == 1) ? 8'h02 : (i == 2) ? 8'h03 : 8'h01);
      end
      $display("test low power count done");
      wr(OFS_REGULATOR_CONFIG_COMPANION, 8'h00_7C);
      for (int i = 0; i < 8; i++)
      begin
         wr(OFS_REGULATOR_CONFIG_PRIMARY, {1'b0, i[2:0], 4'hC});
         check("phases", {5'h00, ph_cnt}, (i > 5) ? 8'h06 : 8'(i + 1));
      end
      chk1("loop test", loop_en, 1'b1);
      chk1("voltage select", vsel, 1'b1);
      check("voltage code", vout, 8'h00_A5);
      wr(OFS_REGULATOR_CONFIG_PRIMARY, 8'h00_50);
      check("voltage code", vout, 8'h00_3C);
      chk1("loop test", loop_en, 1'b0);
      wr(OFS_REGULATOR_CONFIG_PRIMARY, 8'h00_5C);
      wr(OFS_REGULATOR_CONFIG_COMPANION, 8'h00_70);
      chk1("loop test", loop_en, 1'b0);
      chk1("voltage select", vsel, 1'b0);
      $display("test phase and loop done");
      wr(OFS_LOCK_AND_SOFT_RESET, 8'h00_03);
      rd(OFS_REGULATOR_CONFIG_COMPANION, 8'h00_52);
      rd(OFS_MANUFACTURER_CONFIGURATION, 8'h00_07);
      rd(OFS_LOCK_AND_SOFT_RESET, 8'h00_00);
      $display("test soft reset done");
      stall(8'h00);
      wr(OFS_MANUFACTURER_CONFIGURATION, 8'h00_0F);
      stall(8'h01);
      $display("test bus timeout done");
      wr(OFS_LOCK_AND_SOFT_RESET, 8'h00_01);
      chk1("locked", locked, 1'b1);
      wr(OFS_MANUFACTURER_CONFIGURATION, 8'h00_07);
      rd(OFS_MANUFACTURER_CONFIGURATION, 8'h00_0F);
      chk1("timeout enable", tmo_en, 1'b1);
      wr(OFS_LOCK_AND_SOFT_RESET, 8'h00_02);
      rd(OFS_MANUFACTURER_CONFIGURATION, 8'h00_0F);
      rd(8'h00_D7, 8'h00_00);
      $display("test lock done");
      give_verdict();
   end
endmodule
